// File: src/pfc_pkg.sv
// Constants and types for the port flow control register block
package pfc_pkg;

   localparam int unsigned PFC_ADDR_W     = 12;
   localparam int unsigned PFC_DATA_W     = 32;
   localparam int unsigned PFC_BE_W       = 4;
   localparam int unsigned PFC_SYNC_W     = 5;

   localparam logic [11:0] PFC_FC_OFFSET  = 12'h01a0;

   localparam int unsigned PFC_OVR_BIT    = 0;
   localparam int unsigned PFC_TXEN_BIT   = 1;
   localparam int unsigned PFC_RXEN_BIT   = 2;
   localparam int unsigned PFC_LTX_BIT    = 3;
   localparam int unsigned PFC_LRX_BIT    = 4;
   localparam int unsigned PFC_DUP_BIT    = 5;
   localparam int unsigned PFC_BP_BIT     = 6;
   localparam int unsigned PFC_RSVD_LSB   = 7;

   localparam logic        PFC_BP_RST     = 1'b0;
   localparam logic        PFC_PAUSE_RST  = 1'b0;
   localparam logic        PFC_OVR_RST    = 1'b1;
   localparam logic        PFC_DUP_RST    = 1'b1;
   localparam logic        PFC_WAIT_RST   = 1'b1;

   typedef enum logic [1:0] {
      PFC_MODE_INT_PHY,
      PFC_MODE_MII_PHY,
      PFC_MODE_RMII_PHY,
      PFC_MODE_MII_MAC
   } pfc_mode_t;

   // Modes with no negotiation pin the select high
   function automatic logic pfc_forced(input pfc_mode_t mode);
      return mode != PFC_MODE_INT_PHY;
   endfunction : pfc_forced

endpackage : pfc_pkg

// File: src/pfc_cfg_if.sv
// Configuration and live status carried between register file and resolver
`timescale 1ns/1ps
interface pfc_cfg_if;
   logic bp_en;
   logic rx_en;
   logic tx_en;
   logic override;
   logic live_half;
   logic live_rx;
   logic live_tx;
   logic bp_on;

   modport regs (output bp_en, output rx_en, output tx_en, output override,
                 input live_half, input live_rx, input live_tx, input bp_on);
   modport res  (input bp_en, input rx_en, input tx_en, input override,
                 output live_half, output live_rx, output live_tx, output bp_on);
endinterface : pfc_cfg_if

// File: src/pfc_sync.sv
// Two-stage synchroniser for strap and mode pins
`timescale 1ns/1ps
module pfc_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_r;

   if (WIDTH < 1) begin : g_bad_width
      $error("pfc_sync: WIDTH must be at least 1");
   end

   // Free running so the chain is settled while reset is held
   always_ff @(posedge clk) begin
      meta_r <= din;
      dout   <= meta_r;
   end
endmodule : pfc_sync

// File: src/pfc_resolve.sv
// Resolves the pause and backpressure settings actually in effect
`timescale 1ns/1ps
module pfc_resolve
   import pfc_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic an_enable,
   input  wire logic an_pause_rx,
   input  wire logic an_pause_tx,
   input  wire logic link_half,
   pfc_cfg_if.res    cfg
);
   logic manual;

   assign manual = cfg.override | ~an_enable;

   always_ff @(posedge clk) begin
      if (rst) begin
         cfg.live_half <= PFC_DUP_RST;
         cfg.live_rx   <= PFC_PAUSE_RST;
         cfg.live_tx   <= PFC_PAUSE_RST;
         cfg.bp_on     <= PFC_BP_RST;
      end else begin
         cfg.live_half <= link_half;
         // Pause only makes sense on a full-duplex link
         cfg.live_rx   <= ~link_half & (manual ? cfg.rx_en : an_pause_rx);
         cfg.live_tx   <= ~link_half & (manual ? cfg.tx_en : an_pause_tx);
         cfg.bp_on     <= link_half & cfg.bp_en;
      end
   end
endmodule : pfc_resolve

// File: src/pfc_top.sv
// Port flow control register with Avalon-MM slave and live status readback
`timescale 1ns/1ps
module pfc_top
   import pfc_pkg::*;
#(
   parameter int unsigned ADDR_W = PFC_ADDR_W
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic [ADDR_W-1:0]      avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [PFC_DATA_W-1:0]  avs_writedata,
   input  wire logic [PFC_BE_W-1:0]    avs_byteenable,
   output logic      [PFC_DATA_W-1:0]  avs_readdata,
   output logic                        avs_waitrequest,
   input  wire logic                   backpressure_strap,
   input  wire logic                   pause_enable_strap,
   input  wire logic                   override_strap,
   input  wire logic [1:0]             port_mode_pin,
   input  wire logic                   loader_load,
   input  wire logic                   loader_backpressure,
   input  wire logic                   loader_pause_enable,
   input  wire logic                   loader_override,
   input  wire logic                   an_enable,
   input  wire logic                   an_pause_rx,
   input  wire logic                   an_pause_tx,
   input  wire logic                   link_half,
   output logic                        backpressure_on,
   output logic                        pause_rx_on,
   output logic                        pause_tx_on
);
   import pfc_pkg::*;

   if (ADDR_W < 9 || ADDR_W > PFC_DATA_W) begin : g_bad_addr_w
      $error("pfc_top: ADDR_W must lie between 9 and 32");
   end

   pfc_cfg_if cfg ();

   logic [PFC_SYNC_W-1:0] pins_s;
   logic                  bp_strap_s;
   logic                  pause_strap_s;
   logic                  ovr_strap_s;
   pfc_mode_t             mode;
   logic                  forced;
   logic                  strap_pending_r;
   logic                  bp_en_r;
   logic                  rx_en_r;
   logic                  tx_en_r;
   logic                  override_r;
   logic                  wait_r;
   logic [PFC_DATA_W-1:0] rdata_r;
   logic                  req;
   logic                  hit;
   logic                  commit_wr;
   logic                  sw_wr;

   pfc_sync #(
      .WIDTH (PFC_SYNC_W)
   ) u_sync (
      .clk   (clk),
      .din   ({port_mode_pin, override_strap, pause_enable_strap, backpressure_strap}),
      .dout  (pins_s)
   );

   assign bp_strap_s    = pins_s[0];
   assign pause_strap_s = pins_s[1];
   assign ovr_strap_s   = pins_s[2];
   assign mode          = pfc_mode_t'(pins_s[4:3]);
   assign forced        = pfc_forced(mode);

   pfc_resolve u_resolve (
      .clk         (clk),
      .rst         (rst),
      .an_enable   (an_enable),
      .an_pause_rx (an_pause_rx),
      .an_pause_tx (an_pause_tx),
      .link_half   (link_half),
      .cfg         (cfg)
   );

   assign cfg.bp_en    = bp_en_r;
   assign cfg.rx_en    = rx_en_r;
   assign cfg.tx_en    = tx_en_r;
   assign cfg.override = override_r;

   assign backpressure_on = cfg.bp_on;
   assign pause_rx_on     = cfg.live_rx;
   assign pause_tx_on     = cfg.live_tx;

   // Bus decode
   assign req       = avs_read | avs_write;
   assign hit       = avs_address == ADDR_W'(PFC_FC_OFFSET);
   assign commit_wr = avs_write & ~wait_r;
   assign sw_wr     = commit_wr & hit & avs_byteenable[0];

   // One wait cycle per access, unmapped addresses answered the same way
   always_ff @(posedge clk) begin
      if (rst) begin
         wait_r <= PFC_WAIT_RST;
      end else begin
         wait_r <= ~(req & wait_r);
      end
   end

   // Read data captured on the first request edge, stable while wait is low
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_r <= 32'h0000_0000;
      end else if (avs_read & wait_r) begin
         rdata_r <= 32'h0000_0000;
         if (hit) begin
            rdata_r[PFC_BP_BIT]   <= bp_en_r;
            rdata_r[PFC_DUP_BIT]  <= cfg.live_half;
            rdata_r[PFC_LRX_BIT]  <= cfg.live_rx;
            rdata_r[PFC_LTX_BIT]  <= cfg.live_tx;
            rdata_r[PFC_RXEN_BIT] <= rx_en_r;
            rdata_r[PFC_TXEN_BIT] <= tx_en_r;
            rdata_r[PFC_OVR_BIT]  <= override_r;
         end
      end
   end

   assign avs_readdata    = rdata_r;
   assign avs_waitrequest = wait_r;

   // Straps are taken once the synchroniser has filled, right after release
   always_ff @(posedge clk) begin
      if (rst) begin
         strap_pending_r <= 1'b1;
      end else begin
         strap_pending_r <= 1'b0;
      end
   end

   // Loader rewrite beats a software write landing in the same cycle.
   // Nothing here reaches the PHY advertisement bits.
   always_ff @(posedge clk) begin
      if (rst) begin
         bp_en_r <= PFC_BP_RST;
      end else if (strap_pending_r) begin
         bp_en_r <= bp_strap_s;
      end else if (loader_load) begin
         bp_en_r <= loader_backpressure;
      end else if (sw_wr) begin
         bp_en_r <= avs_writedata[PFC_BP_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rx_en_r <= PFC_PAUSE_RST;
         tx_en_r <= PFC_PAUSE_RST;
      end else if (strap_pending_r) begin
         rx_en_r <= pause_strap_s;
         tx_en_r <= pause_strap_s;
      end else if (loader_load) begin
         rx_en_r <= loader_pause_enable;
         tx_en_r <= loader_pause_enable;
      end else if (sw_wr) begin
         rx_en_r <= avs_writedata[PFC_RXEN_BIT];
         tx_en_r <= avs_writedata[PFC_TXEN_BIT];
      end
   end

   // External modes hold the select high and refuse writes and loads
   always_ff @(posedge clk) begin
      if (rst) begin
         override_r <= PFC_OVR_RST;
      end else if (forced) begin
         override_r <= 1'b1;
      end else if (strap_pending_r) begin
         override_r <= ovr_strap_s;
      end else if (loader_load) begin
         override_r <= loader_override;
      end else if (sw_wr) begin
         override_r <= avs_writedata[PFC_OVR_BIT];
      end
   end

   // Checks
   default clocking cb @(posedge clk);
   endclocking

   default disable iff (rst);

   sequence s_first_edge;
      req && wait_r;
   endsequence

   sequence s_read_first;
      avs_read && wait_r && hit;
   endsequence

   sequence s_write_commit;
      sw_wr && !loader_load && !strap_pending_r;
   endsequence

   a_wait_one_cycle : assert property (
      s_first_edge |=> !avs_waitrequest ##1 avs_waitrequest
   ) else $error("waitrequest did not drop for exactly one cycle");

   a_rsvd_read_zero : assert property (
      avs_read && !wait_r |-> avs_readdata[PFC_DATA_W-1:PFC_RSVD_LSB] == '0
   ) else $error("reserved bits read as nonzero");

   a_dup_readback : assert property (
      s_read_first |=> avs_readdata[PFC_DUP_BIT] == $past(cfg.live_half)
   ) else $error("duplex readback mismatch");

   a_live_rx_read : assert property (
      s_read_first |=> avs_readdata[PFC_LRX_BIT] == $past(pause_rx_on)
   ) else $error("pause rx readback mismatch");

   a_bp_write_lands : assert property (
      sw_wr && !loader_load && !strap_pending_r
         |=> bp_en_r == $past(avs_writedata[PFC_BP_BIT]) ##1 backpressure_on == (link_half
             ? bp_en_r : 1'b0) || $past(link_half) != link_half || !$stable(bp_en_r)
   ) else $error("backpressure write not applied");

   a_manual_pause : assert property (
      override_r && !link_half |=> pause_rx_on == $past(rx_en_r)
         && pause_tx_on == $past(tx_en_r)
   ) else $error("override did not select the enable bits");

   a_an_pause : assert property (
      !override_r && an_enable && !link_half
         |=> pause_rx_on == $past(an_pause_rx) && pause_tx_on == $past(an_pause_tx)
   ) else $error("negotiated pause not used");

   a_an_off_pause : assert property (
      !an_enable && !link_half |=> pause_tx_on == $past(tx_en_r)
         && pause_rx_on == $past(rx_en_r)
   ) else $error("enable bits not used with negotiation off");

   a_forced_select : assert property (
      forced |=> override_r
   ) else $error("override not held high in an external mode");

   a_ovr_readonly : assert property (
      forced && sw_wr && !avs_writedata[PFC_OVR_BIT] |=> override_r ##1 override_r
   ) else $error("override written in an external mode");

   a_strap_load : assert property (
      strap_pending_r |=> bp_en_r == $past(bp_strap_s) && rx_en_r == $past(pause_strap_s)
   ) else $error("strap defaults not taken after reset");

   a_loader_update : assert property (
      loader_load && !strap_pending_r |=> bp_en_r == $past(loader_backpressure)
         && tx_en_r == $past(loader_pause_enable)
   ) else $error("loader rewrite not reflected");

   a_wait_idle : assert property (
      !req && wait_r |=> avs_waitrequest
   ) else $error("waitrequest dropped without a request");

   a_rx_write_lands : assert property (
      s_write_commit
         |=> rx_en_r == $past(avs_writedata[PFC_RXEN_BIT])
   ) else $error("pause receive enable write not applied");

   a_tx_write_lands : assert property (
      s_write_commit
         |=> tx_en_r == $past(avs_writedata[PFC_TXEN_BIT])
   ) else $error("pause transmit enable write not applied");

   a_ovr_write_lands : assert property (
      s_write_commit ##0 !forced
         |=> override_r == $past(avs_writedata[PFC_OVR_BIT])
   ) else $error("override write not applied in internal mode");

   a_be_refused : assert property (
      commit_wr && hit && !avs_byteenable[0] && !loader_load && !strap_pending_r
         |=> $stable(bp_en_r) && $stable(rx_en_r) && $stable(tx_en_r)
   ) else $error("write without low byte enable changed a field");

   a_miss_refused : assert property (
      commit_wr && !hit && !loader_load && !strap_pending_r
         |=> $stable(bp_en_r) && $stable(rx_en_r) && $stable(tx_en_r)
   ) else $error("write to an unmapped address changed a field");

   a_miss_read_zero : assert property (
      avs_read && wait_r && !hit |=> avs_readdata == '0
   ) else $error("unmapped read returned nonzero data");

   a_bp_readback : assert property (
      s_read_first |=> avs_readdata[PFC_BP_BIT] == $past(bp_en_r)
   ) else $error("backpressure enable readback mismatch");

   a_live_tx_read : assert property (
      s_read_first |=> avs_readdata[PFC_LTX_BIT] == $past(pause_tx_on)
   ) else $error("pause tx readback mismatch");

   a_enable_read : assert property (
      s_read_first |=> avs_readdata[PFC_RXEN_BIT] == $past(rx_en_r)
         && avs_readdata[PFC_TXEN_BIT] == $past(tx_en_r)
   ) else $error("pause enable readback mismatch");

   a_ovr_readback : assert property (
      s_read_first |=> avs_readdata[PFC_OVR_BIT] == $past(override_r)
   ) else $error("override readback mismatch");

   a_bp_half_only : assert property (
      link_half && bp_en_r |=> backpressure_on
   ) else $error("backpressure missing on a half-duplex link");

   a_bp_full_off : assert property (
      !link_half || !bp_en_r |=> !backpressure_on
   ) else $error("backpressure raised while disabled or full duplex");

   a_half_no_pause : assert property (
      link_half |=> !pause_rx_on && !pause_tx_on
   ) else $error("pause active on a half-duplex link");

   a_loader_ovr_kept : assert property (
      loader_load && forced |=> override_r
   ) else $error("loader cleared override in an external mode");

   a_strap_ovr : assert property (
      strap_pending_r && !forced |=> override_r == $past(ovr_strap_s)
   ) else $error("override strap default not taken");

   a_loader_ovr : assert property (
      loader_load && !strap_pending_r && !forced
         |=> override_r == $past(loader_override) && rx_en_r == $past(loader_pause_enable)
   ) else $error("loader override or receive enable not reflected");

endmodule : pfc_top

// File: dv/tb_port_flow_control_config.sv
// Self-checking bench for the port flow control register block
`timescale 1ns/1ps
module tb_port_flow_control_config;
   import pfc_pkg::*;

   logic                  clk;
   logic                  rst;
   logic [PFC_ADDR_W-1:0] avs_address;
   logic                  avs_read;
   logic                  avs_write;
   logic [PFC_DATA_W-1:0] avs_writedata;
   logic [PFC_BE_W-1:0]   avs_byteenable;
   logic [PFC_DATA_W-1:0] avs_readdata;
   logic                  avs_waitrequest;
   logic                  backpressure_strap;
   logic                  pause_enable_strap;
   logic                  override_strap;
   logic [1:0]            port_mode_pin;
   logic                  loader_load;
   logic                  loader_backpressure;
   logic                  loader_pause_enable;
   logic                  loader_override;
   logic                  an_enable;
   logic                  an_pause_rx;
   logic                  an_pause_tx;
   logic                  link_half;
   logic                  backpressure_on;
   logic                  pause_rx_on;
   logic                  pause_tx_on;
   int                    failures;
   int                    n_checks;
   logic                  m_bp, m_rx, m_tx, m_ovr;
   logic [31:0]           rd;

   pfc_top dut_u (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .backpressure_strap,
      .pause_enable_strap, .override_strap, .port_mode_pin, .loader_load,
      .loader_backpressure, .loader_pause_enable, .loader_override, .an_enable,
      .an_pause_rx, .an_pause_tx, .link_half, .backpressure_on, .pause_rx_on, .pause_tx_on);

   always #2 clk = ~clk;

   task automatic give_verdict();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : give_verdict

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Sample at the edge, before the slave's own updates land
   task automatic wait_ack();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (avs_waitrequest !== 1'b0) begin
         failures++;
         $display("ERROR t=%0t bus answer never came", $time);
         give_verdict();
      end
   endtask : wait_ack

   task automatic bus_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
      @(posedge clk);
      avs_address    <= a;
      avs_writedata  <= d;
      avs_byteenable <= be;
      avs_write      <= 1'b1;
      wait_ack();
      avs_write      <= 1'b0;
   endtask : bus_wr

   task automatic bus_rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_read    <= 1'b1;
      wait_ack();
      d = avs_readdata;
      avs_read    <= 1'b0;
   endtask : bus_rd

   task automatic sw_wr(input logic [31:0] d);
      bus_wr(PFC_FC_OFFSET, d, 4'hf);
      m_bp = d[PFC_BP_BIT];
      m_rx = d[PFC_RXEN_BIT];
      m_tx = d[PFC_TXEN_BIT];
      if (port_mode_pin == 2'h0) m_ovr = d[PFC_OVR_BIT];
   endtask : sw_wr

   function automatic logic [31:0] exp_word();
      logic man, lrx, ltx;
      man = m_ovr | ~an_enable;
      lrx = ~link_half & (man ? m_rx : an_pause_rx);
      ltx = ~link_half & (man ? m_tx : an_pause_tx);
      return {25'h0, m_bp, link_half, lrx, ltx, m_rx, m_tx, m_ovr};
   endfunction : exp_word

   // Live outputs lag one register stage, so let inputs settle first
   task automatic chk_all();
      logic [31:0] e;
      repeat (3) @(posedge clk);
      e = exp_word();
      check({29'h0, backpressure_on, pause_rx_on, pause_tx_on},
            {29'h0, m_bp & link_half, e[PFC_LRX_BIT], e[PFC_LTX_BIT]});
      bus_rd(PFC_FC_OFFSET, rd);
      check(rd, e);
   endtask : chk_all

   task automatic load(input logic b, input logic p, input logic o);
      @(posedge clk);
      loader_load         <= 1'b1;
      loader_backpressure <= b;
      loader_pause_enable <= p;
      loader_override     <= o;
      @(posedge clk);
      loader_load         <= 1'b0;
      m_bp = b;
      m_rx = p;
      m_tx = p;
      if (port_mode_pin == 2'h0) m_ovr = o;
   endtask : load

   task automatic do_reset(input logic b, input logic p, input logic o);
      @(posedge clk);
      rst                <= 1'b1;
      backpressure_strap <= b;
      pause_enable_strap <= p;
      override_strap     <= o;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      m_bp  = b;
      m_rx  = p;
      m_tx  = p;
      m_ovr = o | (port_mode_pin != 2'h0);
   endtask : do_reset

   initial begin
      clk = 0; rst = 1; avs_address = '0; avs_read = 0; avs_write = 0; avs_writedata = '0;
      avs_byteenable = '0; backpressure_strap = 0; pause_enable_strap = 0; override_strap = 0;
      port_mode_pin = 2'h0; loader_load = 0; loader_backpressure = 0; loader_pause_enable = 0;
      loader_override = 0; an_enable = 1; an_pause_rx = 0; an_pause_tx = 0; link_half = 0;
      failures = 0; n_checks = 0;
      do_reset(1'b1, 1'b1, 1'b0);
      chk_all();
      $display("test strap defaults done");
      sw_wr(32'hffff_ffff);
      chk_all();
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         an_enable   <= i[1];
         an_pause_rx <= i[2];
         an_pause_tx <= ~i[2];
         sw_wr(32'h0000_0004 | i[0]);
         chk_all();
      end
      $display("test pause source select done");
      link_half <= 1'b1;
      sw_wr(32'h0000_0047);
      chk_all();
      sw_wr(32'h0000_0007);
      chk_all();
      link_half <= 1'b0;
      $display("test half duplex done");
      sw_wr(32'hffff_ffb8);
      bus_wr(PFC_FC_OFFSET, 32'h0000_0047, 4'he);
      bus_wr(12'h1a4, 32'h0000_0047, 4'hf);
      chk_all();
      bus_rd(12'h1a4, rd);
      check(rd, 32'h0000_0000);
      $display("test refused writes done");
      load(1'b0, 1'b1, 1'b1);
      chk_all();
      load(1'b1, 1'b0, 1'b0);
      chk_all();
      $display("test loader done");
      for (int m = 1; m < 4; m++) begin
         @(posedge clk);
         port_mode_pin <= m[1:0];
         repeat (4) @(posedge clk);
         m_ovr = 1'b1;
         chk_all();
         sw_wr(32'h0000_0006);
         chk_all();
         load(1'b1, 1'b0, 1'b0);
         chk_all();
      end
      @(posedge clk);
      port_mode_pin <= 2'h0;
      repeat (4) @(posedge clk);
      sw_wr(32'h0000_0000);
      chk_all();
      $display("test port modes done");
      do_reset(1'b0, 1'b0, 1'b1);
      chk_all();
      $display("test second reset done");
      give_verdict();
   end
endmodule : tb_port_flow_control_config
